// file: fbpi_pkg.sv
// Purpose: Constants shared by the framebuffer memory pin interface
// Assumes: One 100 MHz clock, synchronous active-high reset
// Notes: Behaviour list below describes the pin interface
// Behaviour
// - A 128-bit two-way memory data bus carries framebuffer transfers.
// - An 8-bit boot ROM of up to 64 KB is reached over data lines 31:0.
// - ROM address on lines 15:0, data in on 31:24, write 17, read 16.
// - A dedicated ROM select output works with the shared data lines.
// - Straps are caught from the 11 address pins during host bus reset.
// - One row, one column and one write strobe serve all memories.
// - With SDRAM the second chip select carries the bank select bit.
// - Sixteen byte masks, one per byte lane, are driven.
// - Each bank has its own clock; a third clock loops back to an input.
// - A clock enable output is driven to the memories.
package fbpi_pkg;
    localparam int DATA_W = 128;
    localparam int ADDR_W = 11;
    localparam int MASK_W = 16;
    localparam int ROM_ADDR_W = 16;
    localparam int ROM_DATA_W = 8;
    localparam int ROM_ADDR_LSB = 0;
    localparam int ROM_OE_BIT = 16;
    localparam int ROM_WE_BIT = 17;
    localparam int ROM_DATA_LSB = 24;
    localparam int ROM_SPAN_W = 32;
    // ROM access phases in clock cycles
    localparam int ROM_ACCESS_NS = 120;
    localparam int CLK_NS = 10;
    localparam logic [3:0] ROM_CYCLES = 4'(
        (ROM_ACCESS_NS + CLK_NS - 1) / CLK_NS);
    localparam logic [ADDR_W-1:0] STRAP_RST = 11'h000;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_MEM = 3'b010,
        ST_ROM = 3'b100
    } fbpi_state_e;
endpackage : fbpi_pkg

// file: fbpi_strap.sv
// Purpose: Catches strap levels from the address pins during host reset
// Assumes: Host reset is synchronous to clk
// Notes: Address pins are undriven while host reset is low
`timescale 1ns/1ps
`default_nettype none
module fbpi_strap (
    // Clock and reset
    input wire logic clk,
    input wire logic srst,
    // Strap sampling
    input wire logic host_bus_reset_n,
    input wire logic [fbpi_pkg::ADDR_W-1:0] addr_pins_in,
    output logic [fbpi_pkg::ADDR_W-1:0] strap_value,
    output logic strap_valid
);
    typedef struct packed {
        logic [fbpi_pkg::ADDR_W-1:0] straps;
        logic valid;
    } fbpi_strap_s;
    fbpi_strap_s st_ff;
    fbpi_strap_s nxt_st;

    always_comb begin
        nxt_st = st_ff;
        if (!host_bus_reset_n) begin
            nxt_st.straps = addr_pins_in;
            nxt_st.valid = 1'b0;
        end else begin
            nxt_st.valid = 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            st_ff <= '{straps: fbpi_pkg::STRAP_RST, valid: 1'b0};
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign strap_value = st_ff.straps;
    assign strap_valid = st_ff.valid;
endmodule : fbpi_strap
`default_nettype wire

// file: fbpi_top.sv
// Purpose: Pin-level framebuffer memory and boot ROM interface
// Assumes: Memory controller gives one command per cycle
// Notes: Command timing lives in the controller, not here
`timescale 1ns/1ps
`default_nettype none
module fbpi_top (
    // Clock and reset
    input wire logic clk,
    input wire logic srst,
    // Host reset and straps
    input wire logic host_bus_reset_n,
    output logic [fbpi_pkg::ADDR_W-1:0] strap_value,
    output logic strap_valid,
    // Memory command side
    input wire logic mem_req,
    input wire logic mem_write,
    input wire logic mem_ras,
    input wire logic mem_cas,
    input wire logic mem_we,
    input wire logic [1:0] mem_cs,
    input wire logic sdram_mode,
    input wire logic mem_bank,
    input wire logic mem_cke_req,
    input wire logic [fbpi_pkg::ADDR_W-1:0] mem_addr,
    input wire logic [fbpi_pkg::DATA_W-1:0] mem_wdata,
    input wire logic [fbpi_pkg::MASK_W-1:0] mem_mask,
    output logic mem_ready,
    output logic [fbpi_pkg::DATA_W-1:0] mem_rdata,
    // ROM command side
    input wire logic rom_req,
    input wire logic rom_write,
    input wire logic [fbpi_pkg::ROM_ADDR_W-1:0] rom_addr,
    input wire logic [fbpi_pkg::ROM_DATA_W-1:0] rom_wdata,
    output logic rom_ready,
    output logic rom_done,
    output logic [fbpi_pkg::ROM_DATA_W-1:0] rom_rdata,
    // Memory pins
    input wire logic [fbpi_pkg::DATA_W-1:0] mem_data_bus_in,
    output logic [fbpi_pkg::DATA_W-1:0] mem_data_bus_out,
    output logic [fbpi_pkg::DATA_W-1:0] mem_data_bus_oe,
    input wire logic [fbpi_pkg::ADDR_W-1:0] mem_addr_bus_in,
    output logic [fbpi_pkg::ADDR_W-1:0] mem_addr_bus_out,
    output logic mem_addr_bus_oe,
    output logic mem_row_strobe_n,
    output logic mem_col_strobe_n,
    output logic mem_write_strobe_n,
    output logic [1:0] mem_chip_sel_n,
    output logic [fbpi_pkg::MASK_W-1:0] mem_byte_mask,
    output logic mem_clk_bank0,
    output logic mem_clk_bank1,
    output logic mem_clk_loop_out,
    input wire logic mem_clk_loop_in,
    output logic mem_clk_en,
    output logic mem_clk_locked,
    // ROM select pin
    output logic boot_rom_sel_n
);
    localparam int RL = fbpi_pkg::ROM_DATA_LSB;
    localparam int RW = fbpi_pkg::ROM_DATA_W;

    typedef struct packed {
        fbpi_pkg::fbpi_state_e state;
        logic [3:0] cnt;
        logic rom_wr;
        logic rom_done;
        logic [RW-1:0] rom_rdata;
        logic [fbpi_pkg::ROM_ADDR_W-1:0] rom_addr;
        logic [RW-1:0] rom_wdata;
        logic ras_n;
        logic cas_n;
        logic we_n;
        logic [1:0] cs_n;
        logic cke;
        logic drive;
        logic [fbpi_pkg::ADDR_W-1:0] addr;
        logic [fbpi_pkg::DATA_W-1:0] wdata;
        logic [fbpi_pkg::MASK_W-1:0] mask;
        logic [fbpi_pkg::DATA_W-1:0] rdata;
        logic loop_seen;
    } fbpi_top_s;
    fbpi_top_s st_ff;
    fbpi_top_s nxt_st;
    logic rom_phase;
    logic host_rst_active;

    fbpi_strap u_strap (
        .clk(clk),
        .srst(srst),
        .host_bus_reset_n(host_bus_reset_n),
        .addr_pins_in(mem_addr_bus_in),
        .strap_value(strap_value),
        .strap_valid(strap_valid)
    );

    assign host_rst_active = !host_bus_reset_n;
    // Memory commands win only when no ROM cycle is open
    assign mem_ready = (st_ff.state != fbpi_pkg::ST_ROM) && !host_rst_active;
    assign rom_ready = (st_ff.state == fbpi_pkg::ST_IDLE) && !mem_req
        && !host_rst_active;

    always_comb begin
        nxt_st = st_ff;
        nxt_st.rom_done = 1'b0;
        // Loopback clock only reports that the board returns the clock
        nxt_st.loop_seen = mem_clk_loop_in;
        unique case (st_ff.state)
            fbpi_pkg::ST_IDLE, fbpi_pkg::ST_MEM: begin
                nxt_st.ras_n = 1'b1;
                nxt_st.cas_n = 1'b1;
                nxt_st.we_n = 1'b1;
                nxt_st.cs_n = 2'b11;
                nxt_st.drive = 1'b0;
                nxt_st.state = fbpi_pkg::ST_IDLE;
                nxt_st.cke = mem_cke_req;
                if (mem_req && mem_ready) begin
                    nxt_st.state = fbpi_pkg::ST_MEM;
                    nxt_st.ras_n = !mem_ras;
                    nxt_st.cas_n = !mem_cas;
                    nxt_st.we_n = !mem_we;
                    nxt_st.cs_n[0] = !mem_cs[0];
                    // SDRAM reuses the second select as bank bit
                    nxt_st.cs_n[1] = sdram_mode ? mem_bank : !mem_cs[1];
                    nxt_st.addr = mem_addr;
                    nxt_st.wdata = mem_wdata;
                    nxt_st.mask = mem_mask;
                    nxt_st.drive = mem_write;
                end else if (rom_req && rom_ready) begin
                    nxt_st.state = fbpi_pkg::ST_ROM;
                    nxt_st.cnt = fbpi_pkg::ROM_CYCLES;
                    nxt_st.rom_wr = rom_write;
                    nxt_st.rom_addr = rom_addr;
                    nxt_st.rom_wdata = rom_wdata;
                end
                if (st_ff.state == fbpi_pkg::ST_MEM && !st_ff.drive) begin
                    nxt_st.rdata = mem_data_bus_in;
                end
            end
            fbpi_pkg::ST_ROM: begin
                nxt_st.cnt = st_ff.cnt - 4'h1;
                if (st_ff.cnt == 4'h1) begin
                    nxt_st.state = fbpi_pkg::ST_IDLE;
                    nxt_st.rom_done = 1'b1;
                    nxt_st.rom_rdata = mem_data_bus_in[RL +: RW];
                end
            end
            default: begin
                nxt_st.state = fbpi_pkg::ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            st_ff <= '0;
            st_ff.state <= fbpi_pkg::ST_IDLE;
            st_ff.ras_n <= 1'b1;
            st_ff.cas_n <= 1'b1;
            st_ff.we_n <= 1'b1;
            st_ff.cs_n <= 2'b11;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign rom_phase = (st_ff.state == fbpi_pkg::ST_ROM);

    // Pins: ROM cycles reuse the low 32 data lines
    always_comb begin
        mem_data_bus_out = st_ff.wdata;
        mem_data_bus_oe = {fbpi_pkg::DATA_W{st_ff.drive}};
        if (rom_phase) begin
            mem_data_bus_out = '0;
            mem_data_bus_oe = '0;
            mem_data_bus_out[fbpi_pkg::ROM_ADDR_LSB +: fbpi_pkg::ROM_ADDR_W] =
                st_ff.rom_addr;
            mem_data_bus_oe[fbpi_pkg::ROM_ADDR_LSB +: fbpi_pkg::ROM_ADDR_W] =
                '1;
            mem_data_bus_out[fbpi_pkg::ROM_OE_BIT] = st_ff.rom_wr;
            mem_data_bus_out[fbpi_pkg::ROM_WE_BIT] = !st_ff.rom_wr;
            mem_data_bus_oe[fbpi_pkg::ROM_OE_BIT] = 1'b1;
            mem_data_bus_oe[fbpi_pkg::ROM_WE_BIT] = 1'b1;
            if (st_ff.rom_wr) begin
                mem_data_bus_out[RL +: RW] = st_ff.rom_wdata;
                mem_data_bus_oe[RL +: RW] = '1;
            end
        end
    end

    // Address pins stay released while host reset holds straps
    assign mem_addr_bus_out = st_ff.addr;
    assign mem_addr_bus_oe = !host_rst_active;
    assign mem_row_strobe_n = st_ff.ras_n;
    assign mem_col_strobe_n = st_ff.cas_n;
    assign mem_write_strobe_n = st_ff.we_n;
    assign mem_chip_sel_n = st_ff.cs_n;
    assign mem_byte_mask = st_ff.mask;
    assign mem_clk_en = st_ff.cke;
    // Bank clocks are forwarded separately to limit skew and load
    assign mem_clk_bank0 = clk;
    assign mem_clk_bank1 = clk;
    assign mem_clk_loop_out = clk;
    assign mem_clk_locked = st_ff.loop_seen;
    assign boot_rom_sel_n = !rom_phase;
    assign rom_done = st_ff.rom_done;
    assign rom_rdata = st_ff.rom_rdata;
    assign mem_rdata = st_ff.rdata;
endmodule : fbpi_top
`default_nettype wire

// file: fbpi_props.sv
// Purpose: Port checks for the pin interface
// Assumes: One clock; srst disables every check
// Notes: Bound onto fbpi_top
`timescale 1ns/1ps
`default_nettype none
module fbpi_props (
    // Clock, reset and requests
    input wire logic clk,
    input wire logic srst,
    input wire logic host_bus_reset_n,
    input wire logic mem_req,
    input wire logic mem_ras,
    input wire logic mem_cas,
    input wire logic sdram_mode,
    input wire logic mem_bank,
    input wire logic rom_req,
    input wire logic rom_write,
    input wire logic [15:0] rom_addr,
    // Design outputs
    input wire logic mem_ready,
    input wire logic rom_ready,
    input wire logic rom_done,
    input wire logic [127:0] mem_data_bus_out,
    input wire logic mem_addr_bus_oe,
    input wire logic mem_row_strobe_n,
    input wire logic mem_col_strobe_n,
    input wire logic [1:0] mem_chip_sel_n,
    input wire logic boot_rom_sel_n
);
    default clocking @(posedge clk); endclocking
    default disable iff (srst);
    wire logic mem_go = mem_req && mem_ready;
    wire logic rom_go = rom_req && rom_ready;
    sequence s_busy; !boot_rom_sel_n [*8] ##1 !boot_rom_sel_n [*4]; endsequence
    sequence s_end; boot_rom_sel_n && rom_done; endsequence
    property p_row; mem_go |=> mem_row_strobe_n != $past(mem_ras); endproperty
    a_row: assert property (p_row) else $error("row strobe");
    property p_col; mem_go |=> mem_col_strobe_n != $past(mem_cas); endproperty
    a_col: assert property (p_col) else $error("col strobe");
    property p_bank;
        mem_go && sdram_mode |=> mem_chip_sel_n[1] == $past(mem_bank);
    endproperty
    a_bank: assert property (p_bank) else $error("bank bit");
    property p_rom_len; rom_go |=> s_busy ##1 s_end; endproperty
    a_rom_len: assert property (p_rom_len) else $error("rom length");
    property p_rom_addr;
        rom_go |=> mem_data_bus_out[16:0] == {$past(rom_write), $past(rom_addr)};
    endproperty
    a_rom_addr: assert property (p_rom_addr) else $error("rom addr");
    property p_rom_we; rom_go |=> mem_data_bus_out[17] != $past(rom_write); endproperty
    a_rom_we: assert property (p_rom_we) else $error("rom write");
    property p_excl;
        !boot_rom_sel_n |-> !mem_ready && mem_row_strobe_n && mem_col_strobe_n;
    endproperty
    a_excl: assert property (p_excl) else $error("rom overlap");
    property p_host;
        !host_bus_reset_n |-> !mem_addr_bus_oe && !mem_ready && !rom_ready;
    endproperty
    a_host: assert property (p_host) else $error("strap window");
endmodule : fbpi_props
bind fbpi_top fbpi_props u_props (.*);
`default_nettype wire

// file: fbpi_mem_model.sv
// Purpose: Behavioural memory and boot ROM on the far side
// Assumes: Reads answer while the column strobe is low
// Notes: Undriven lines show the inverse of the last value
`timescale 1ns/1ps
`default_nettype none
module fbpi_mem_model (
    // Device pins
    input wire logic [127:0] dq_out,
    input wire logic [127:0] dq_oe,
    input wire logic [10:0] addr,
    input wire logic col_n,
    input wire logic we_n,
    input wire logic rom_sel_n,
    // Resolved data lines
    output logic [127:0] dq_in
);
    always_comb begin
        dq_in = ~dq_out;
        if (!col_n && we_n) begin
            dq_in = {8{addr, 5'h15}};
        end
        if (!rom_sel_n && !dq_out[16]) begin
            dq_in[31:24] = dq_out[7:0] ^ dq_out[15:8];
        end
        dq_in = (dq_out & dq_oe) | (dq_in & ~dq_oe);
    end
endmodule : fbpi_mem_model
`default_nettype wire

// file: fbpi_top_tb.sv
// Purpose: Random and corner tests of the pin interface
// Assumes: Memory and ROM model on the far side
// Notes: Commands run back to back; pin checks lag one edge
`timescale 1ns/1ps
`default_nettype none
module fbpi_top_tb;
    typedef struct packed {
        logic rq, rd, ras, bk, sd, ck;
        logic [1:0] cs;
        logic [10:0] a;
        logic [15:0] m;
        logic [127:0] w;
    } fbpi_cmd_s;
    logic clk = 1'b0, srst = 1'b1, host_bus_reset_n = 1'b0, mem_req = 1'b0;
    logic mem_write = 1'b0, mem_ras = 1'b0, mem_cas = 1'b0, mem_we = 1'b0;
    logic sdram_mode = 1'b0, mem_bank = 1'b0, mem_cke_req = 1'b0;
    logic rom_req = 1'b0, rom_write = 1'b0, mem_clk_loop_in;
    logic [1:0] mem_cs = 2'h0, mem_chip_sel_n;
    logic [10:0] mem_addr = 11'h000, strap, strap_value;
    logic [10:0] mem_addr_bus_in, mem_addr_bus_out;
    logic [15:0] mem_mask = 16'h0000, rom_addr = 16'h0000, mem_byte_mask;
    logic [7:0] rom_wdata = 8'h00, rom_rdata;
    logic [127:0] mem_wdata = '0, mem_rdata, mem_data_bus_in;
    logic [127:0] mem_data_bus_out, mem_data_bus_oe;
    logic strap_valid, mem_ready, rom_ready, rom_done, mem_addr_bus_oe;
    logic mem_row_strobe_n, mem_col_strobe_n, mem_write_strobe_n;
    logic mem_clk_bank0, mem_clk_bank1, mem_clk_loop_out, mem_clk_en;
    logic mem_clk_locked, boot_rom_sel_n;
    int i, n, err_count = 0, checks_done = 0;
    fbpi_cmd_s c, p, q;
    // Straps are pull resistors until the device drives the pins
    assign mem_addr_bus_in = mem_addr_bus_oe ? mem_addr_bus_out : strap;
    assign mem_clk_loop_in = mem_clk_loop_out;
    fbpi_top dut (.*);
    fbpi_mem_model u_mem (.dq_out(mem_data_bus_out), .dq_oe(mem_data_bus_oe),
        .addr(mem_addr_bus_out), .col_n(mem_col_strobe_n),
        .we_n(mem_write_strobe_n), .rom_sel_n(boot_rom_sel_n),
        .dq_in(mem_data_bus_in));
    always #5 clk = ~clk;
    task automatic chk(input string nm, input logic [127:0] s, e);
        checks_done++;
        if (s !== e) begin
            err_count++;
            $display("[ERR] %s exp %h got %h", nm, e, s);
        end
    endtask : chk
    task automatic final_report();
        $display("checks %0d errors %0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : final_report
    task automatic rom_op(input logic wr, input logic [15:0] a);
        @(posedge clk);
        rom_req <= 1'b1;
        rom_write <= wr;
        rom_addr <= a;
        rom_wdata <= a[15:8];
        @(posedge clk);
        rom_req <= 1'b0;
        mem_req <= 1'b1;
        mem_ras <= 1'b1;
        for (n = 1; n < 30; n++) begin
            @(posedge clk);
            #1;
            if (n == 1) begin
                chk("rom_pins", mem_data_bus_out[17:0], {!wr, wr, a});
                chk("refuse", {mem_ready, mem_row_strobe_n}, 2'h1);
                chk("rom_sel", boot_rom_sel_n, 1'b0);
                if (wr) begin
                    chk("rom_wd", mem_data_bus_out[31:24], a[15:8]);
                end
                mem_req <= 1'b0;
            end
            if (rom_done === 1'b1) break;
        end
        chk("rom_len", n, fbpi_pkg::ROM_CYCLES);
        if (n == 30) final_report();
        if (!wr) chk("rom_data", rom_rdata, a[7:0] ^ a[15:8]);
    endtask : rom_op
    initial begin
        void'($urandom(32'h0000_f03d));
        strap = 11'($urandom);
        p = '0;
        q = '0;
        repeat (6) @(posedge clk);
        srst <= 1'b0;
        repeat (2) @(posedge clk);
        host_bus_reset_n <= 1'b1;
        repeat (2) @(posedge clk);
        #1;
        chk("strap", {strap_valid, strap_value}, {1'b1, strap});
        chk("idle", {mem_row_strobe_n, mem_chip_sel_n}, 3'h7);
        chk("clks", {mem_clk_bank0, mem_clk_bank1}, 2'h3);
        for (i = 0; i < 42; i++) begin
            @(posedge clk);
            c = fbpi_cmd_s'(163'({$urandom, $urandom, $urandom, $urandom,
                $urandom, $urandom}));
            c.rq = i < 40;
            if (i == 0) c.m = 16'hffff;
            mem_req <= c.rq;
            mem_write <= !c.rd;
            mem_ras <= c.ras;
            mem_cas <= 1'b1;
            mem_we <= !c.rd;
            mem_cs <= c.cs;
            sdram_mode <= c.sd;
            mem_bank <= c.bk;
            mem_cke_req <= c.ck;
            mem_addr <= c.a;
            mem_mask <= c.m;
            mem_wdata <= c.w;
            #1;
            if (p.rq) begin
                chk("strobes", {mem_row_strobe_n, mem_col_strobe_n,
                    mem_write_strobe_n}, {!p.ras, 1'b0, p.rd});
                chk("cs", mem_chip_sel_n,
                    {p.sd ? p.bk : !p.cs[1], !p.cs[0]});
                chk("mask", mem_byte_mask, p.m);
                chk("cke", mem_clk_en, p.ck);
                if (!p.rd) begin
                    chk("wdata", mem_data_bus_out & mem_data_bus_oe,
                        p.w);
                end
            end
            if (q.rq && q.rd) begin
                chk("rdata", mem_rdata, {8{q.a, 5'h15}});
            end
            q = p;
            p = c;
        end
        for (i = 0; i < 6; i++) rom_op(i[0], 16'($urandom));
        final_report();
    end
endmodule : fbpi_top_tb
`default_nettype wire
